// File: rtl/bpdm_cfg.svh
// Purpose: constants for the byte port with data bus mux
// Assumes: byte-wide register port, 40 MHz system clock
// Notes: offsets are the printed byte offsets of the port registers
`ifndef BPDM_CFG_SVH
`define BPDM_CFG_SVH
`define BPDM_ADDR_W 16
`define BPDM_OFS_DATA 16'h0000
`define BPDM_OFS_DIR 16'h0002
`define BPDM_OFS_FUNC 16'h0003
`define BPDM_BUS_FUNC_BIT 0
`define BPDM_DIR_RESET 8'h00
`define BPDM_FUNC_RESET 8'h00
`define BPDM_LATCH_RESET 8'h00
`endif

// File: rtl/bpdm_decode.sv
// Purpose: address decode for the port registers
// Assumes: address is stable beside its strobe
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "bpdm_cfg.svh"
module bpdm_decode (
    input wire logic [`BPDM_ADDR_W-1:0] addr,
    output bpdm_pkg::bpdm_sel_e sel
);
    always_comb begin
        case (addr)
            `BPDM_OFS_DATA: sel = bpdm_pkg::BPDM_SEL_DATA;
            `BPDM_OFS_DIR: sel = bpdm_pkg::BPDM_SEL_DIR;
            `BPDM_OFS_FUNC: sel = bpdm_pkg::BPDM_SEL_FUNC;
            default: sel = bpdm_pkg::BPDM_SEL_NONE;
        endcase
    end
endmodule
`default_nettype wire

// File: rtl/bpdm_pin_mux.sv
// Purpose: whole-port role selection between port and data bus
// Assumes: bus controller supplies its own drive and enable
// Notes: combinational; the top registers the results
`timescale 1ns/10ps
`default_nettype none
module bpdm_pin_mux #(
    parameter int WIDTH = 8
) (
    input wire logic busMode,
    input wire logic [WIDTH-1:0] dirBits,
    input wire logic [WIDTH-1:0] latchVal,
    input wire logic [WIDTH-1:0] busDataOut,
    input wire logic busDataOe,
    output logic [WIDTH-1:0] pinOutNext,
    output logic [WIDTH-1:0] pinOeNext
);
    always_comb begin
        if (busMode) begin
            pinOutNext = busDataOut;
            pinOeNext = {WIDTH{busDataOe}};
        end else begin
            pinOutNext = latchVal;
            pinOeNext = dirBits;
        end
    end
endmodule
`default_nettype wire

// File: rtl/bpdm_pkg.sv
// Purpose: types for the byte port with data bus mux
// Assumes: nothing
// Notes: register selection enumeration
package bpdm_pkg;
    typedef enum logic [1:0] {
        BPDM_SEL_NONE,
        BPDM_SEL_DATA,
        BPDM_SEL_DIR,
        BPDM_SEL_FUNC
    } bpdm_sel_e;
endpackage

// File: rtl/bpdm_port.sv
// Purpose: 8-bit general-purpose port that doubles as data bus low byte
// Assumes: register strobes are one cycle, read data one cycle later
// Notes: direction and function registers are write-only
//
// Summary of operation
// - eight pins, each set as input or output by its own direction bit.
// - all eight pins can serve as data bus lines 0 to 7.
// - after reset every pin is an input; software enables bus use.
// - output latch clears on reset; data reads return pin levels.
// - function bit 0 chooses port use (0) or data bus use (1).
// - direction 0 means input, 1 drives the latch; all reset to 0.
// - data register writes update the latch driving output pins only.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "bpdm_cfg.svh"
module bpdm_port #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [`BPDM_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut,
    output logic [WIDTH-1:0] pinOe,
    input wire logic [WIDTH-1:0] busDataOut,
    input wire logic busDataOe,
    output logic [WIDTH-1:0] busDataIn,
    output logic busModeOut
);
    // ******************************************************
    // checks
    // ******************************************************
    // refused at elaboration: the register bus is a byte wide
    if (WIDTH != 8) begin
        $error("bpdm_port serves only an 8-bit port");
    end

    // ******************************************************
    // decode
    // ******************************************************
    bpdm_pkg::bpdm_sel_e sel;
    logic [WIDTH-1:0] dir_reg;
    logic [WIDTH-1:0] latch_reg;
    logic busFunc_reg;
    logic [WIDTH-1:0] pinOutNext;
    logic [WIDTH-1:0] pinOeNext;

    bpdm_decode uDecode (
        .addr(regAddr),
        .sel(sel)
    );

    // ******************************************************
    // registers
    // ******************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dir_reg <= `BPDM_DIR_RESET;
        end else if (regWrite && sel == bpdm_pkg::BPDM_SEL_DIR) begin
            dir_reg <= regWdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busFunc_reg <= 1'b0;
        end else if (regWrite && sel == bpdm_pkg::BPDM_SEL_FUNC) begin
            busFunc_reg <= regWdata[`BPDM_BUS_FUNC_BIT];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            latch_reg <= `BPDM_LATCH_RESET;
        end else if (regWrite && sel == bpdm_pkg::BPDM_SEL_DATA) begin
            latch_reg <= regWdata;
        end
    end

    // ******************************************************
    // readback
    // ******************************************************
    // write-only and unmapped registers read as zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regRead && sel == bpdm_pkg::BPDM_SEL_DATA) begin
            regRdata <= pinIn;
        end else begin
            regRdata <= 8'h00;
        end
    end

    // ******************************************************
    // pins
    // ******************************************************
    bpdm_pin_mux #(
        .WIDTH(WIDTH)
    ) uMux (
        .busMode(busFunc_reg),
        .dirBits(dir_reg),
        .latchVal(latch_reg),
        .busDataOut(busDataOut),
        .busDataOe(busDataOe),
        .pinOutNext(pinOutNext),
        .pinOeNext(pinOeNext)
    );

    // registered pins add one cycle of latency after a register write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pinOut <= '0;
            pinOe <= '0;
        end else begin
            pinOut <= pinOutNext;
            pinOe <= pinOeNext;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busDataIn <= '0;
            busModeOut <= 1'b0;
        end else begin
            busDataIn <= pinIn;
            busModeOut <= busFunc_reg;
        end
    end
endmodule
`default_nettype wire

// File: verif/bpdm_pin_model.sv
// Purpose: pin levels | Assumes: undriven pins show extVal | Notes: none
`timescale 1ns/10ps
`default_nettype none
module bpdm_pin_model (
    input wire logic [7:0] pinOut, pinOe, extVal,
    output logic [7:0] pinIn
);
    assign pinIn = (pinOe & pinOut) | (~pinOe & extVal);
endmodule
`default_nettype wire

// File: verif/bpdm_port_checker.sv
// Purpose: port checks | Assumes: one clock | Notes: bound below
`timescale 1ns/10ps
`default_nettype none
`include "bpdm_cfg.svh"
module bpdm_port_checker #(parameter int WIDTH = 8) (
    input wire logic sys_clk, rst, regWrite, regRead, busDataOe, busModeOut,
    input wire logic [`BPDM_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata, regRdata,
    input wire logic [WIDTH-1:0] pinIn, pinOut, pinOe, busDataOut, busDataIn
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_reset_inputs: assert property ($fell(rst) |-> pinOe == '0)
        else $error("pins driven");
    a_read_pins: assert property (regRead && regAddr == 16'h0000
        |=> regRdata == $past(pinIn)) else $error("bad pin read");
    a_wo_zero: assert property (regRead && regAddr[15:1] == 15'h0001
        |=> regRdata == 8'h00) else $error("bad wo read");
    a_rdata_idle: assert property (!regRead |=> regRdata == 8'h00)
        else $error("rdata not idle");
    a_dir_drive: assert property ((regWrite && regAddr == 16'h0002)
        ##1 !busModeOut |=> pinOe == $past(regWdata, 2)) else $error("oe");
    a_latch_out: assert property ((regWrite && regAddr == 16'h0000)
        ##1 !busModeOut |=> (pinOut & pinOe) == ($past(regWdata, 2) & pinOe))
        else $error("latch");
    // busModeOut and the pins are loaded at one edge from one function bit
    a_bus_mode: assert property (busModeOut
        |-> pinOut == $past(busDataOut) && pinOe == {WIDTH{$past(busDataOe)}})
        else $error("bus drive");
    a_bus_in: assert property (1'b1 |=> busDataIn == $past(pinIn))
        else $error("bus input");
endmodule
bind bpdm_port bpdm_port_checker #(.WIDTH(WIDTH)) chk (
    .sys_clk(sys_clk),
    .rst(rst),
    .regWrite(regWrite),
    .regRead(regRead),
    .busDataOe(busDataOe),
    .busModeOut(busModeOut),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regRdata(regRdata),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .busDataOut(busDataOut),
    .busDataIn(busDataIn)
);
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: port bench | Assumes: 40 MHz | Notes: random, seed fixed
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic busDataOe = 1'b0, busModeOut;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWdata = 8'h00, extVal = 8'h00, busDataOut = 8'h00;
    logic [7:0] regRdata, pinIn, pinOut, pinOe, busDataIn, dirV, latV;
    int miscompares = 0, tests_run = 0;
    bpdm_port uut (.*);
    bpdm_pin_model pm (.*);
    initial forever #12.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a, logic [7:0] d);
        @(posedge sys_clk);
        regWrite <= w;
        regRead <= !w;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        #1;
    endtask
    task automatic give_verdict;
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        void'($urandom(90385));
        @(posedge sys_clk);
        extVal <= 8'($urandom);
        repeat (15) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk(pinOe | pinOut, 8'h00);
        acc(1'b0, 16'h0000, 8'h00);
        chk(regRdata, extVal);
        // unmapped and write-only places read back zero
        for (int a = 1; a < 4; a++) begin
            acc(1'b0, 16'(a), 8'h00);
            chk(regRdata, 8'h00);
        end
        $display("test reset done");
        repeat (20) begin
            dirV = 8'($urandom);
            latV = 8'($urandom);
            @(posedge sys_clk);
            extVal <= 8'($urandom);
            acc(1'b1, 16'h0002, dirV);
            acc(1'b1, 16'h0000, latV);
            @(posedge sys_clk);
            #1;
            chk(pinOe, dirV);
            acc(1'b0, 16'h0000, 8'h00);
            chk(regRdata, (dirV & latV) | (~dirV & extVal));
        end
        $display("test port done");
        @(posedge sys_clk);
        busDataOut <= 8'($urandom);
        busDataOe <= 1'b1;
        acc(1'b1, 16'h0003, 8'h01);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(pinOut, busDataOut);
        chk(pinOe, 8'hff);
        chk({7'h00, busModeOut}, 8'h01);
        chk(busDataIn, busDataOut);
        // bus controller lets go: pins fall back to the outside levels
        @(posedge sys_clk);
        busDataOe <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(pinOe, 8'h00);
        chk(busDataIn, extVal);
        acc(1'b1, 16'h0003, 8'hfe);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(pinOe, dirV);
        chk({7'h00, busModeOut}, 8'h00);
        $display("test bus done");
        give_verdict();
    end
    initial begin
        #100us;
        miscompares++;
        give_verdict();
    end
endmodule
`default_nettype wire
